//--- hw/crsl_pkg.sv
package crsl_pkg;

  // Byte offsets on the control and status interface
  localparam logic [7:0] CRSL_OFS_RX_CTRL_RB = 8'h38;
  localparam logic [7:0] CRSL_OFS_RX_ERR_CNT = 8'h3C;
  localparam logic [7:0] CRSL_OFS_RX_FRM_NUM = 8'h40;
  localparam logic [7:0] CRSL_OFS_LOOPBACK   = 8'h44;

  // Field positions
  localparam int CRSL_SHE_LSB = 8;
  localparam int CRSL_SHE_MSB = 15;
  localparam int CRSL_LCV_LSB = 0;
  localparam int CRSL_LCV_MSB = 7;
  localparam int CRSL_BFN_LSB = 0;
  localparam int CRSL_BFN_MSB = 11;
  localparam int CRSL_LBR_LSB = 8;
  localparam int CRSL_LBR_MSB = 10;
  localparam int CRSL_LBF_LSB = 0;
  localparam int CRSL_LBF_MSB = 1;

  // Reset values
  localparam logic [31:0] CRSL_RST_RX_CTRL = 32'h0000_0000;
  localparam logic [7:0]  CRSL_RST_CNT     = 8'h00;
  localparam logic [11:0] CRSL_RST_BFN     = 12'h000;
  localparam logic [2:0]  CRSL_RST_LBR     = 3'h0;
  localparam logic [1:0]  CRSL_RST_LBF     = 2'h0;

  // Reverse loopback encodings
  localparam logic [2:0] CRSL_LBR_NONE    = 3'h0;
  localparam logic [2:0] CRSL_LBR_FULL    = 3'h1;
  localparam logic [2:0] CRSL_LBR_IQ      = 3'h2;
  localparam logic [2:0] CRSL_LBR_FCM     = 3'h3;
  localparam logic [2:0] CRSL_LBR_FCM_VS  = 3'h4;

  // Forward loopback encodings
  localparam logic [1:0] CRSL_LBF_NONE    = 2'h0;
  localparam logic [1:0] CRSL_LBF_SERIAL  = 2'h1;
  localparam logic [1:0] CRSL_LBF_DELAY   = 2'h2;
  localparam logic [1:0] CRSL_LBF_FRAMING = 2'h3;

  // Wait cycles inserted before an access is taken
  localparam int CRSL_ACC_WAIT = 1;

  typedef enum logic [0:0] {
    CRSL_ST_IDLE,
    CRSL_ST_ACK
  } crsl_acc_e;

endpackage

//--- hw/crsl_regs.sv
`timescale 1ns/10ps
// How it works
// - An access is stretched by wait-request so read data and write effect come more than one cycle after the request.
// - A read-only 32-bit register returns the last received control-word section that matched the selection.
// - The captured control word position is the X index given by the receive control-word index field.
// - The receive section-select field picks which of the five 32-bit sections of that word is captured.
// - Sync-header violations are counted in bits 15:8 and reading the register clears the count.
// - The sync-header count wraps from 255 to zero instead of saturating.
// - Line-code violations are counted in bits 7:0 and reading the register clears the count.
// - The line-code count rolls over from 255 to zero.
// - Line-code violations are counted whether or not the link has synchronised yet.
// - The current received basic frame number is shown as a 12-bit read-only field reset to zero.
// - A 3-bit read-write field in bits 10:8 selects what the reverse loopback path returns.
// - Reverse loopback codes are 0 none, 1 whole frame, 2 data only, 3 fast control, 4 fast control and vendor words.
// - The 2-bit forward loopback field in bits 1:0 selects none, serial, delay path or framing path.
module crsl_regs
  import crsl_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // Control and status interface
  input  wire logic [7:0]  cpu_address_i,
  input  wire logic        cpu_read_i,
  input  wire logic        cpu_write_i,
  input  wire logic [31:0] cpu_writedata_i,
  output logic [31:0]      cpu_readdata_o,
  output logic             cpu_readdatavalid_o,
  output logic             cpu_waitrequest_o,
  // Control-word selection from the index register
  input  wire logic [7:0]  rx_ctrl_x_sel_i,
  input  wire logic [2:0]  rx_ctrl_seq_sel_i,
  // Received control-word sections
  input  wire logic        rx_ctrl_valid_i,
  input  wire logic [7:0]  rx_ctrl_x_i,
  input  wire logic [2:0]  rx_ctrl_seq_i,
  input  wire logic [31:0] rx_ctrl_data_i,
  // Receive error events and frame number
  input  wire logic        sync_header_error_i,
  input  wire logic        line_code_error_i,
  input  wire logic [11:0] rx_bfn_i,
  // Loopback selection
  output logic [2:0]       loop_reversed_o,
  output logic [1:0]       loop_forward_o
);

  crsl_acc_e   state_q;
  logic        acc_go;
  logic        acc_rd;
  logic        acc_wr;
  logic [31:0] rx_ctrl_q;
  logic [7:0]  sync_header_error_count_q;
  logic [7:0]  lcv_count_q;
  logic [11:0] bfn_q;
  logic [2:0]  loop_rev_q;
  logic [1:0]  loop_fwd_q;
  logic        err_clr;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic rev_code_ok(input logic [2:0] code);
    rev_code_ok = (code <= CRSL_LBR_FCM_VS);
  endfunction

  // Access handshake; one wait cycle mirrors the clock-crossing latency
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= CRSL_ST_IDLE;
    end else begin
      case (state_q)
        CRSL_ST_IDLE: begin
          if (cpu_read_i || cpu_write_i) begin
            state_q <= CRSL_ST_ACK;
          end
        end
        CRSL_ST_ACK: begin
          state_q <= CRSL_ST_IDLE;
        end
        default: begin
          state_q <= CRSL_ST_IDLE;
        end
      endcase
    end
  end

  assign acc_go            = (state_q == CRSL_ST_ACK) && (cpu_read_i || cpu_write_i);
  assign acc_rd            = acc_go && cpu_read_i;
  assign acc_wr            = acc_go && cpu_write_i && !cpu_read_i;
  assign cpu_waitrequest_o = (cpu_read_i || cpu_write_i) && (state_q != CRSL_ST_ACK);
  assign err_clr           = acc_rd && hit(cpu_address_i, CRSL_OFS_RX_ERR_CNT);

  // Control-word capture for the selected position and section
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_ctrl_q <= CRSL_RST_RX_CTRL;
    end else if (rx_ctrl_valid_i && rx_ctrl_x_i == rx_ctrl_x_sel_i
                 && rx_ctrl_seq_i == rx_ctrl_seq_sel_i) begin
      rx_ctrl_q <= rx_ctrl_data_i;
    end
  end

  // Error counters; an event in the clearing cycle survives as a count of one
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_header_error_count_q <= CRSL_RST_CNT;
    end else if (err_clr) begin
      sync_header_error_count_q <= {7'h00, sync_header_error_i};
    end else if (sync_header_error_i) begin
      sync_header_error_count_q <= sync_header_error_count_q + 8'h01;
    end
  end

  // No link-sync qualifier: errors during initialisation count too
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lcv_count_q <= CRSL_RST_CNT;
    end else if (err_clr) begin
      lcv_count_q <= {7'h00, line_code_error_i};
    end else if (line_code_error_i) begin
      lcv_count_q <= lcv_count_q + 8'h01;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bfn_q <= CRSL_RST_BFN;
    end else begin
      bfn_q <= rx_bfn_i;
    end
  end

  // Loopback control; undefined reverse codes are dropped so no stray path turns on
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loop_rev_q <= CRSL_RST_LBR;
      loop_fwd_q <= CRSL_RST_LBF;
    end else if (acc_wr && hit(cpu_address_i, CRSL_OFS_LOOPBACK)) begin
      if (rev_code_ok(cpu_writedata_i[CRSL_LBR_MSB:CRSL_LBR_LSB])) begin
        loop_rev_q <= cpu_writedata_i[CRSL_LBR_MSB:CRSL_LBR_LSB];
      end
      loop_fwd_q <= cpu_writedata_i[CRSL_LBF_MSB:CRSL_LBF_LSB];
    end
  end

  assign loop_reversed_o = loop_rev_q;
  assign loop_forward_o  = loop_fwd_q;

  // Read data
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_readdata_o <= 32'h0000_0000;
    end else if (acc_rd) begin
      cpu_readdata_o <= 32'h0000_0000;
      case (cpu_address_i)
        CRSL_OFS_RX_CTRL_RB: begin
          cpu_readdata_o <= rx_ctrl_q;
        end
        CRSL_OFS_RX_ERR_CNT: begin
          cpu_readdata_o[CRSL_SHE_MSB:CRSL_SHE_LSB] <= sync_header_error_count_q;
          cpu_readdata_o[CRSL_LCV_MSB:CRSL_LCV_LSB] <= lcv_count_q;
        end
        CRSL_OFS_RX_FRM_NUM: begin
          cpu_readdata_o[CRSL_BFN_MSB:CRSL_BFN_LSB] <= bfn_q;
        end
        CRSL_OFS_LOOPBACK: begin
          cpu_readdata_o[CRSL_LBR_MSB:CRSL_LBR_LSB] <= loop_rev_q;
          cpu_readdata_o[CRSL_LBF_MSB:CRSL_LBF_LSB] <= loop_fwd_q;
        end
        default: begin
          cpu_readdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_readdatavalid_o <= 1'b0;
    end else begin
      cpu_readdatavalid_o <= acc_rd;
    end
  end

  property p_read_latency;
    @(posedge clock_i) disable iff (!resetn_i)
      (state_q == CRSL_ST_IDLE && cpu_read_i) |-> cpu_waitrequest_o ##1 !cpu_waitrequest_o ##1 cpu_readdatavalid_o;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("Read answer timing wrong");

  property p_capture;
    @(posedge clock_i) disable iff (!resetn_i)
      (rx_ctrl_valid_i && rx_ctrl_x_i == rx_ctrl_x_sel_i && rx_ctrl_seq_i == rx_ctrl_seq_sel_i)
      |=> rx_ctrl_q == $past(rx_ctrl_data_i);
  endproperty
  a_capture: assert property (p_capture) else $error("Control word not captured");

  property p_no_capture;
    @(posedge clock_i) disable iff (!resetn_i)
      (rx_ctrl_valid_i && (rx_ctrl_x_i != rx_ctrl_x_sel_i || rx_ctrl_seq_i != rx_ctrl_seq_sel_i))
      |=> $stable(rx_ctrl_q);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("Unselected control word captured");

  property p_err_clear;
    @(posedge clock_i) disable iff (!resetn_i)
      (err_clr && !sync_header_error_i && !line_code_error_i)
      |=> sync_header_error_count_q == 8'h00 && lcv_count_q == 8'h00 && cpu_readdatavalid_o;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("Read did not clear counters");

  property p_she_wrap;
    @(posedge clock_i) disable iff (!resetn_i)
      (sync_header_error_count_q == 8'hFF && sync_header_error_i && !err_clr) |=> sync_header_error_count_q == 8'h00;
  endproperty
  a_she_wrap: assert property (p_she_wrap) else $error("Sync header count did not wrap");

  property p_lcv_inc;
    @(posedge clock_i) disable iff (!resetn_i)
      (line_code_error_i && !err_clr) |=> lcv_count_q == $past(lcv_count_q) + 8'h01;
  endproperty
  a_lcv_inc: assert property (p_lcv_inc) else $error("Line code error not counted");

  property p_bfn;
    @(posedge clock_i) disable iff (!resetn_i)
      1'b1 |=> bfn_q == $past(rx_bfn_i);
  endproperty
  a_bfn: assert property (p_bfn) else $error("Frame number not tracked");

  property p_rev_write;
    @(posedge clock_i) disable iff (!resetn_i)
      (acc_wr && hit(cpu_address_i, CRSL_OFS_LOOPBACK)
       && cpu_writedata_i[CRSL_LBR_MSB:CRSL_LBR_LSB] <= CRSL_LBR_FCM_VS)
      |=> loop_reversed_o == $past(cpu_writedata_i[CRSL_LBR_MSB:CRSL_LBR_LSB]);
  endproperty
  a_rev_write: assert property (p_rev_write) else $error("Reverse loopback write lost");

  property p_rev_legal;
    @(posedge clock_i) disable iff (!resetn_i)
      loop_reversed_o <= CRSL_LBR_FCM_VS;
  endproperty
  a_rev_legal: assert property (p_rev_legal) else $error("Undefined reverse loopback code");

  property p_fwd_write;
    @(posedge clock_i) disable iff (!resetn_i)
      (acc_wr && hit(cpu_address_i, CRSL_OFS_LOOPBACK))
      |=> loop_forward_o == $past(cpu_writedata_i[CRSL_LBF_MSB:CRSL_LBF_LSB]);
  endproperty
  a_fwd_write: assert property (p_fwd_write) else $error("Forward loopback write lost");

endmodule

//--- tb/crsl_link_model.sv
`timescale 1ns/10ps
module crsl_link_model (
  // Clock
  input  wire logic clock_i,
  // Received control-word sections
  output logic        valid_o,
  output logic [7:0]  x_o,
  output logic [2:0]  seq_o,
  output logic [31:0] data_o,
  // Error events and frame number
  output logic        sync_hdr_o,
  output logic        code_err_o,
  output logic [11:0] bfn_o
);
  initial begin
    {valid_o, x_o, seq_o, data_o, sync_hdr_o, code_err_o, bfn_o} = '0;
  end
  task automatic sec(input logic [7:0] x, input logic [2:0] s, input logic [31:0] d);
    @(posedge clock_i);
    #1;
    {valid_o, x_o, seq_o, data_o} = {1'b1, x, s, d};
    @(posedge clock_i);
    #1;
    // Idle bus shows junk, never the last word
    {valid_o, x_o, data_o} = {1'b0, ~x, ~d};
  endtask
  // Back-to-back pulses, one per cycle
  task automatic pulses(input int ns, input int nl);
    for (int i = 0; i < ns || i < nl; i++) begin
      @(posedge clock_i);
      #1;
      {sync_hdr_o, code_err_o} = {i < ns, i < nl};
    end
    @(posedge clock_i);
    #1;
    {sync_hdr_o, code_err_o} = 2'b00;
  endtask
  task automatic frame(input logic [11:0] b);
    @(posedge clock_i);
    #1;
    bfn_o = b;
  endtask
endmodule

//--- tb/tb_cpri_rx_status_loopback_regs.sv
`timescale 1ns/10ps
module tb_cpri_rx_status_loopback_regs
  import crsl_pkg::*;
;
  logic clock_i = 0, resetn_i = 0, rd_s = 0, wr_s = 0, rdv, wrq, cv, she, lcv;
  logic [7:0] adr = 0, xsel = 0, cx;
  logic [2:0] ssel = 0, cs, lbr_o, m_lbr = 0;
  logic [31:0] wdat = 0, rdat, cd, v, m_rb;
  logic [11:0] bfn, m_bfn;
  logic [1:0] lbf_o, m_lbf = 0;
  int fails = 0, checked = 0, seed = 92994, cyc = 0, m_she, m_lcv;
  crsl_regs DUT (.clock_i(clock_i), .resetn_i(resetn_i), .cpu_address_i(adr), .cpu_read_i(rd_s),
    .cpu_write_i(wr_s), .cpu_writedata_i(wdat), .cpu_readdata_o(rdat), .cpu_readdatavalid_o(rdv),
    .cpu_waitrequest_o(wrq), .rx_ctrl_x_sel_i(xsel), .rx_ctrl_seq_sel_i(ssel), .rx_ctrl_valid_i(cv),
    .rx_ctrl_x_i(cx), .rx_ctrl_seq_i(cs), .rx_ctrl_data_i(cd), .sync_header_error_i(she),
    .line_code_error_i(lcv), .rx_bfn_i(bfn), .loop_reversed_o(lbr_o), .loop_forward_o(lbf_o));
  crsl_link_model lnk (.clock_i(clock_i), .valid_o(cv), .x_o(cx), .seq_o(cs), .data_o(cd),
    .sync_hdr_o(she), .code_err_o(lcv), .bfn_o(bfn));
  initial forever #50 clock_i = ~clock_i;
  // Whole run needs under a thousand cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_rd(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_lp(input logic [4:0] e);
    checked++;
    if ({lbr_o, lbf_o} !== e) begin
      fails++;
      $display("BAD loop outputs exp %h got %h", e, {lbr_o, lbf_o});
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    #1;
    {adr, wdat, wr_s, rd_s} = {a, wd, w, !w};
    #2;
    chk_rd("waitrequest", 32'h1, {31'h0, wrq});
    while (wrq !== 1'b0 && k < 20) begin
      @(posedge clock_i);
      #3;
      k++;
    end
    if (k == 20) fails++;
    @(posedge clock_i);
    #1;
    {wr_s, rd_s} = 2'b00;
    d = rdat;
    if (!w) chk_rd("readdatavalid", 32'h1, {31'h0, rdv});
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, v);
    chk_rd(n, e, v);
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    #1;
    resetn_i = 1;
    chk_lp(5'h00);
    rdc("rx_ctrl", CRSL_OFS_RX_CTRL_RB, CRSL_RST_RX_CTRL);
    rdc("rx_err", CRSL_OFS_RX_ERR_CNT, 32'h0);
    rdc("bfn", CRSL_OFS_RX_FRM_NUM, 32'h0);
    rdc("unmapped", 8'h48, 32'h0);
    $display("test reset done");
    for (int s = 0; s < 5; s++) begin
      xsel = 8'($random(seed));
      ssel = 3'(s);
      m_rb = $random(seed);
      lnk.sec(xsel + 8'h1, ssel, ~m_rb);
      lnk.sec(xsel, ssel, m_rb);
      lnk.sec(xsel, 3'((s + 1) % 5), ~m_rb);
      rdc("rx_ctrl", CRSL_OFS_RX_CTRL_RB, m_rb);
    end
    $display("test capture done");
    for (int r = 0; r < 3; r++) begin
      m_she = r * 200 + {$random(seed)} % 40;
      m_lcv = r * 128 + {$random(seed)} % 4;
      lnk.pulses(m_she, m_lcv);
      rdc("rx_err", CRSL_OFS_RX_ERR_CNT, {16'h0, 8'(m_she % 256), 8'(m_lcv % 256)});
      rdc("rx_err cleared", CRSL_OFS_RX_ERR_CNT, 32'h0);
    end
    // Events in the clearing cycle must survive the read-clear
    fork
      lnk.pulses(3, 3);
      rdc("rx_err overlap", CRSL_OFS_RX_ERR_CNT, 32'h0000_0101);
    join
    rdc("rx_err after overlap", CRSL_OFS_RX_ERR_CNT, 32'h0000_0202);
    $display("test counters done");
    repeat (3) begin
      m_bfn = 12'($random(seed));
      lnk.frame(m_bfn);
      rdc("bfn", CRSL_OFS_RX_FRM_NUM, {20'h0, m_bfn});
    end
    $display("test frame number done");
    // Reverse paths treated as built in, endpoint under test as slave
    for (int c = 0; c < 8; c++) begin
      v = $random(seed);
      if (c < 5) m_lbr = 3'(c);
      m_lbf = v[1:0];
      acc(1'b1, CRSL_OFS_LOOPBACK, {v[31:11], 3'(c), v[7:0]}, v);
      chk_lp({m_lbr, m_lbf});
      rdc("loopback", CRSL_OFS_LOOPBACK, {21'h0, m_lbr, 6'h0, m_lbf});
    end
    $display("test loopback done");
    @(posedge clock_i);
    #1;
    resetn_i = 0;
    repeat (2) @(posedge clock_i);
    #1;
    resetn_i = 1;
    chk_lp(5'h00);
    rdc("loopback", CRSL_OFS_LOOPBACK, 32'h0);
    rdc("rx_ctrl", CRSL_OFS_RX_CTRL_RB, 32'h0);
    $display("test second reset done");
    summarize();
  end
endmodule
